/* File: rtl/ulst_regs.vh */
`ifndef ULST_REGS_VH
`define ULST_REGS_VH

// ==========================================================================
// register offsets on the register port
// ==========================================================================
`define ULST_A_CTRL         3'h1
`define ULST_A_FRAME        3'h3
`define ULST_A_LINE_STATUS  3'h5
`define ULST_A_RX_LEVEL     3'h6

// ==========================================================================
// control register fields
// ==========================================================================
`define ULST_CTRL_THR_IE    0
`define ULST_CTRL_FIFO_EN   1
`define ULST_CTRL_RESET     8'h00
`define ULST_FRAME_RESET    4'hA

// ==========================================================================
// line status fields
// ==========================================================================
`define ULST_LS_DATA_READY  0
`define ULST_LS_OVERRUN     1
`define ULST_LS_PARITY      2
`define ULST_LS_FRAMING     3
`define ULST_LS_BREAK       4
`define ULST_LS_THR_EMPTY   5
`define ULST_LS_TX_EMPTY    6
`define ULST_LS_FIFO_ERR    7
`define ULST_LS_RESET       8'h60

// ==========================================================================
// receive queue sizes and timing
// ==========================================================================
`define ULST_FIFO_DEPTH     6'h20
`define ULST_HOLD_DEPTH     6'h01
`define ULST_TAG_W          3
`define ULST_PTR_W          5
`define ULST_OVERSAMPLE     4

`endif

/* File: rtl/ulst_tag_mem.v */
`timescale 1ns/1ps
`include "ulst_regs.vh"

// ==========================================================================
// error tag store, one entry per queued receive character
// ==========================================================================
module ulst_tag_mem (
  // clock
  input  wire                     clk_sys,
  // write side
  input  wire                     wr_en,
  input  wire [`ULST_PTR_W-1:0]   wr_addr,
  input  wire [`ULST_TAG_W-1:0]   wr_tag,
  // read side
  input  wire [`ULST_PTR_W-1:0]   rd_addr,
  output reg  [`ULST_TAG_W-1:0]   rd_tag_q
);

  reg [`ULST_TAG_W-1:0] mem_q [0:31];

  // storage needs no reset; tags are only read for queued characters
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_tag;
    end
    rd_tag_q <= mem_q[rd_addr];
  end

endmodule // ulst_tag_mem

/* File: rtl/ulst_brk_det.v */
`timescale 1ns/1ps
`include "ulst_regs.vh"

// ==========================================================================
// break detector: receive line low for one whole frame
// ==========================================================================
module ulst_brk_det (
  // clock, reset, enable
  input  wire       clk_sys,
  input  wire       resetn,
  input  wire       ce,
  // line and timing
  input  wire       rx_pin,
  input  wire       baud_tick,
  input  wire [3:0] frame_bits,
  // result
  output reg        brk_q
);

  reg       sync1_q;
  reg       sync2_q;
  reg       armed_q;
  reg [7:0] cnt_q;
  wire [7:0] limit;

  // one frame is frame_bits times the oversampling ticks
  assign limit = {frame_bits, {`ULST_OVERSAMPLE{1'b0}}};

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      armed_q <= 1'b1;
      cnt_q   <= 8'h00;
      brk_q   <= 1'b0;
    end else if (ce) begin
      sync1_q <= rx_pin;
      sync2_q <= sync1_q;
      brk_q   <= 1'b0;
      if (sync2_q) begin
        armed_q <= 1'b1;
        cnt_q   <= 8'h00;
      end else if (baud_tick && armed_q) begin
        if (cnt_q + 8'h01 >= limit) begin
          brk_q   <= 1'b1;
          armed_q <= 1'b0;
          cnt_q   <= 8'h00;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

endmodule // ulst_brk_det

/* File: rtl/ulst_top.v */
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "ulst_regs.vh"

module ulst_top (
  // clock, reset, enable
  input  wire       clk_sys,
  input  wire       resetn,
  input  wire       ce,
  // register port
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rd_data_q,
  // transmit path
  input  wire       thr_write,
  input  wire       tsr_load,
  input  wire       tx_fifo_empty,
  input  wire       tsr_empty,
  // receive path
  input  wire       rx_char_valid,
  input  wire       rx_char_pe,
  input  wire       rx_char_fe,
  input  wire       rx_pop,
  input  wire       rx_pin,
  input  wire       baud_tick,
  // results
  output reg        rx_push_q,
  output reg        rx_push_brk_q,
  output reg        thr_irq_q,
  output reg        data_ready_q
);

  // ========================================================================
  // declarations
  // ========================================================================
  reg  [7:0]             ctrl_q;
  reg  [3:0]             frame_q;
  reg                    thre_q;
  reg                    thre_d;
  reg                    temt_q;
  reg                    temt_d;
  reg                    txe_prev_q;
  reg                    ovr_q;
  reg                    fifo_err_q;
  reg  [`ULST_TAG_W-1:0] top_err_q;
  reg  [5:0]             rx_cnt_q;
  reg  [5:0]             rx_cnt_d;
  reg  [`ULST_PTR_W-1:0] wr_ptr_q;
  reg  [`ULST_PTR_W-1:0] rd_ptr_q;
  reg  [1:0]             topev_q;
  reg  [7:0]             rd_mux;
  wire                   fifo_en;
  wire                   thr_ie;
  wire                   brk_evt;
  wire                   ch_in;
  wire [`ULST_TAG_W-1:0] ch_tag;
  wire [5:0]             depth;
  wire                   rx_full;
  wire                   do_push;
  wire                   do_pop;
  wire                   ovr_set;
  wire                   top_new;
  wire                   ls_read;
  wire                   ctrl_wr;
  wire                   mode_chg;
  wire                   thre_set;
  wire [`ULST_TAG_W-1:0] top_tag;
  wire [7:0]             line_status;

  assign fifo_en = ctrl_q[`ULST_CTRL_FIFO_EN];
  assign thr_ie  = ctrl_q[`ULST_CTRL_THR_IE];

  // ========================================================================
  // break detection
  // ========================================================================
  ulst_brk_det u_brk (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .ce         (ce),
    .rx_pin     (rx_pin),
    .baud_tick  (baud_tick),
    .frame_bits (frame_q),
    .brk_q      (brk_evt)
  );

  // ========================================================================
  // receive queue accounting
  // ========================================================================
  // a break arrives as one character tagged break plus framing
  assign ch_in   = rx_char_valid | brk_evt;
  assign ch_tag  = brk_evt ? 3'h6 : {1'b0, rx_char_fe, rx_char_pe};
  assign depth   = fifo_en ? `ULST_FIFO_DEPTH : `ULST_HOLD_DEPTH;
  assign rx_full = (rx_cnt_q >= depth);
  assign do_push = ch_in & ~rx_full;
  assign ovr_set = ch_in & rx_full;
  assign do_pop  = rx_pop & (rx_cnt_q != 6'h00);
  assign ctrl_wr = wr & (addr == `ULST_A_CTRL);
  assign mode_chg = ctrl_wr & (wdata[`ULST_CTRL_FIFO_EN] != fifo_en);

  // a new character reaches the top of the queue
  assign top_new = (do_push & ~do_pop & (rx_cnt_q == 6'h00)) |
                   (do_pop & ~do_push & (rx_cnt_q > 6'h01)) |
                   (do_pop & do_push & (rx_cnt_q == 6'h01)) |
                   (do_pop & do_push & (rx_cnt_q > 6'h01));

  always @* begin
    rx_cnt_d = rx_cnt_q;
    if (do_push && !do_pop) begin
      rx_cnt_d = rx_cnt_q + 6'h01;
    end else if (do_pop && !do_push) begin
      rx_cnt_d = rx_cnt_q - 6'h01;
    end
  end

  ulst_tag_mem u_tags (
    .clk_sys  (clk_sys),
    .wr_en    (do_push & ce),
    .wr_addr  (wr_ptr_q),
    .wr_tag   (ch_tag),
    .rd_addr  (rd_ptr_q),
    .rd_tag_q (top_tag)
  );

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_cnt_q      <= 6'h00;
      wr_ptr_q      <= 5'h00;
      rd_ptr_q      <= 5'h00;
      topev_q       <= 2'h0;
      rx_push_q     <= 1'b0;
      rx_push_brk_q <= 1'b0;
      data_ready_q  <= 1'b0;
    end else if (ce) begin
      rx_push_q     <= do_push;
      rx_push_brk_q <= do_push & brk_evt;
      // switching modes empties the queue
      if (mode_chg) begin
        rx_cnt_q     <= 6'h00;
        wr_ptr_q     <= 5'h00;
        rd_ptr_q     <= 5'h00;
        topev_q      <= 2'h0;
        data_ready_q <= 1'b0;
      end else begin
        rx_cnt_q     <= rx_cnt_d;
        data_ready_q <= (rx_cnt_d != 6'h00);
        topev_q      <= {topev_q[0], top_new};
        if (do_push) begin
          wr_ptr_q <= wr_ptr_q + 5'h01;
        end
        if (do_pop) begin
          rd_ptr_q <= rd_ptr_q + 5'h01;
        end
      end
    end
  end

  // ========================================================================
  // receive error flags
  // ========================================================================
  assign ls_read = rd & (addr == `ULST_A_LINE_STATUS);

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ovr_q      <= 1'b0;
      fifo_err_q <= 1'b0;
      top_err_q  <= 3'h0;
    end else if (ce) begin
      // a new event beats the clear of a read in the same cycle
      ovr_q <= ovr_set | (ovr_q & ~ls_read);
      fifo_err_q <= (do_push & (ch_tag != 3'h0)) |
                    (fifo_err_q & ~ls_read & ~mode_chg);
      if (mode_chg) begin
        top_err_q <= 3'h0;
      end else if (topev_q[1]) begin
        top_err_q <= top_tag | (top_err_q & {3{~ls_read}});
      end else if (ls_read) begin
        top_err_q <= 3'h0;
      end
    end
  end

  // ========================================================================
  // transmit status and interrupt request
  // ========================================================================
  assign thre_set = fifo_en ? (tx_fifo_empty & ~txe_prev_q) : tsr_load;

  always @* begin
    // a host load in the same cycle as a move leaves the holding stage full
    if (thr_write) begin
      thre_d = 1'b0;
    end else if (thre_set) begin
      thre_d = 1'b1;
    end else begin
      thre_d = thre_q;
    end
    if (fifo_en) begin
      temt_d = tx_fifo_empty & tsr_empty;
    end else begin
      temt_d = thre_d & tsr_empty;
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      thre_q     <= 1'b1;
      temt_q     <= 1'b1;
      txe_prev_q <= 1'b1;
      thr_irq_q  <= 1'b0;
    end else if (ce) begin
      thre_q     <= thre_d;
      temt_q     <= temt_d;
      txe_prev_q <= tx_fifo_empty;
      thr_irq_q  <= thre_d & thr_ie;
    end
  end

  // ========================================================================
  // line status assembly
  // ========================================================================
  assign line_status = {fifo_err_q & fifo_en,
                        temt_q,
                        thre_q,
                        top_err_q,
                        ovr_q,
                        data_ready_q};

  // ========================================================================
  // register port
  // ========================================================================
  always @* begin
    case (addr)
      `ULST_A_CTRL:        rd_mux = ctrl_q;
      `ULST_A_FRAME:       rd_mux = {4'h0, frame_q};
      `ULST_A_LINE_STATUS: rd_mux = line_status;
      `ULST_A_RX_LEVEL:    rd_mux = {2'h0, rx_cnt_q};
      default:             rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_q    <= `ULST_CTRL_RESET;
      frame_q   <= `ULST_FRAME_RESET;
      rd_data_q <= 8'h00;
    end else if (ce) begin
      rd_data_q <= rd ? rd_mux : 8'h00;
      if (wr) begin
        case (addr)
          `ULST_A_CTRL:  ctrl_q  <= {6'h00, wdata[1:0]};
          `ULST_A_FRAME: frame_q <= wdata[3:0];
          // line status and level are read-only; writes fall here
          default:       ctrl_q  <= ctrl_q;
        endcase
      end
    end
  end

endmodule // ulst_top

/* File: verif/ulst_top_props.sv */
`timescale 1ns/1ps
// ==========================================================================
// line status checker
// ==========================================================================
module ulst_top_props (
  // clock, reset, enable
  input wire       clk_sys,
  input wire       resetn,
  input wire       ce,
  // register port
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rd_data_q,
  // transmit path
  input wire       thr_write,
  input wire       tsr_load,
  input wire       tx_fifo_empty,
  input wire       tsr_empty,
  // receive path
  input wire       rx_char_valid,
  input wire       rx_pop,
  // results
  input wire       rx_push_q,
  input wire       rx_push_brk_q,
  input wire       thr_irq_q,
  input wire       data_ready_q
);
  reg ie_q;
  reg fifo_q;

  // shadow of the control register fields
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ie_q   <= 1'b0;
      fifo_q <= 1'b0;
    end else if (ce && wr && addr == 3'h1) begin
      ie_q   <= wdata[0];
      fifo_q <= wdata[1];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn || !ce);

  sequence s_ls_read;
    rd && addr == 3'h5 && !rx_char_valid;
  endsequence
  sequence s_no_brk;
    !rx_push_brk_q [*8];
  endsequence

  property p_irq_off;
    !ie_q && !wr |=> !thr_irq_q;
  endproperty
  property p_thr_clear;
    thr_write |=> !thr_irq_q;
  endproperty
  property p_tsr_set;
    tsr_load && !thr_write && ie_q && !fifo_q && !wr |=> thr_irq_q;
  endproperty
  property p_fifo_set;
    $rose(tx_fifo_empty) && !thr_write && ie_q && fifo_q && !wr |=> thr_irq_q;
  endproperty
  property p_push;
    rx_char_valid && !data_ready_q |=> rx_push_q && data_ready_q;
  endproperty
  property p_overrun;
    rx_char_valid && data_ready_q && !rx_pop && !fifo_q && !wr |=> !rx_push_q;
  endproperty
  property p_brk_once;
    rx_push_brk_q |-> rx_push_q ##1 s_no_brk;
  endproperty
  property p_tx_busy;
    s_ls_read and !$past(tsr_empty) |=> !rd_data_q[6];
  endproperty
  property p_read_clear;
    s_ls_read ##1 !rx_char_valid ##1 s_ls_read |=> !rd_data_q[7];
  endproperty

  a_irq_off: assert property (p_irq_off) else $error("irq without enable");
  a_thr_clear: assert property (p_thr_clear) else $error("irq after write");
  a_tsr_set: assert property (p_tsr_set) else $error("no irq after load");
  a_fifo_set: assert property (p_fifo_set) else $error("no irq on empty");
  a_push: assert property (p_push) else $error("char not queued");
  a_overrun: assert property (p_overrun) else $error("push when full");
  a_brk_once: assert property (p_brk_once) else $error("extra break char");
  a_tx_busy: assert property (p_tx_busy) else $error("tx empty while busy");
  a_read_clear: assert property (p_read_clear) else $error("bit7 kept");
endmodule // ulst_top_props

/* File: verif/ulst_host_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// host cpu on the register port
// ==========================================================================
module ulst_host_model (
  // clock
  input  wire       clk_sys,
  // register port
  output reg  [2:0] addr,
  output reg  [7:0] wdata,
  output reg        wr,
  output reg        rd,
  input  wire [7:0] rd_data_q
);
  initial begin
    addr  = 3'h0;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // idle address and data show the inverse of the last value
  task bus_write(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_sys);
      addr  <= ~a;
      wdata <= ~d;
      wr    <= 1'b0;
    end
  endtask

  task bus_read(input [2:0] a, output [7:0] d);
    begin
      @(posedge clk_sys);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_sys);
      addr <= ~a;
      rd   <= 1'b0;
      #1 d = rd_data_q;
    end
  endtask
endmodule // ulst_host_model

/* File: verif/ulst_top_tb_top.sv */
`timescale 1ns/1ps
// ==========================================================================
// line status testbench
// ==========================================================================
module ulst_top_tb_top;
  reg        clk_sys;
  reg        resetn;
  reg        thr_write;
  reg        tsr_load;
  reg        tx_fifo_empty;
  reg        tsr_empty;
  reg        rx_char_valid;
  reg        rx_char_pe;
  reg        rx_char_fe;
  reg        rx_pop;
  reg        rx_pin;
  reg        pushed;
  wire [2:0] addr;
  wire [7:0] wdata;
  wire       wr;
  wire       rd;
  wire [7:0] rd_data_q;
  wire       rx_push_q;
  wire       rx_push_brk_q;
  wire       thr_irq_q;
  wire       data_ready_q;
  integer    fails;
  integer    cmp_count;
  integer    brk_cnt;
  integer    i;

  ulst_top u_ulst_top (
    .clk_sys, .resetn, .ce(1'b1), .addr, .wdata, .wr, .rd, .rd_data_q, .thr_write,
    .tsr_load, .tx_fifo_empty, .tsr_empty, .rx_char_valid, .rx_char_pe, .rx_char_fe,
    .rx_pop, .rx_pin, .baud_tick(1'b1), .rx_push_q, .rx_push_brk_q, .thr_irq_q,
    .data_ready_q
  );
  ulst_host_model u_ulst_host_model (.clk_sys, .addr, .wdata, .wr, .rd, .rd_data_q);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) if (rx_push_brk_q === 1'b1) brk_cnt = brk_cnt + 1;

  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task bchk(input got, input exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task rchk(input [2:0] a, input [7:0] exp);
    reg [7:0] d;
    begin
      u_ulst_host_model.bus_read(a, d);
      chk(d, exp);
    end
  endtask
  task rx_char(input pe, input fe);
    begin
      @(posedge clk_sys);
      rx_char_valid <= 1'b1;
      rx_char_pe    <= pe;
      rx_char_fe    <= fe;
      @(posedge clk_sys);
      rx_char_valid <= 1'b0;
      #1 pushed = rx_push_q;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  task tdone(input integer n);
    $display("test %0d done", n);
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    fails = fails + 1;
    complete_run;
  end

  initial begin
    fails = 0;
    cmp_count = 0;
    brk_cnt = 0;
    resetn = 1'b0;
    thr_write = 1'b0;
    tsr_load = 1'b0;
    tx_fifo_empty = 1'b1;
    tsr_empty = 1'b1;
    rx_char_valid = 1'b0;
    rx_char_pe = 1'b0;
    rx_char_fe = 1'b0;
    rx_pop = 1'b0;
    rx_pin = 1'b1;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    // reset values, unmapped read, ignored write
    rchk(3'h5, 8'h60);
    rchk(3'h1, 8'h00);
    rchk(3'h3, 8'h0A);
    rchk(3'h7, 8'h00);
    u_ulst_host_model.bus_write(3'h5, 8'hFF);
    rchk(3'h5, 8'h60);
    tdone(1);
    // transmit without fifos
    u_ulst_host_model.bus_write(3'h1, 8'h01);
    @(posedge clk_sys);
    #1 bchk(thr_irq_q, 1'b1);
    @(posedge clk_sys);
    thr_write <= 1'b1;
    tsr_empty <= 1'b0;
    tx_fifo_empty <= 1'b0;
    @(posedge clk_sys);
    thr_write <= 1'b0;
    #1 bchk(thr_irq_q, 1'b0);
    rchk(3'h5, 8'h00);
    @(posedge clk_sys);
    tsr_load <= 1'b1;
    tx_fifo_empty <= 1'b1;
    @(posedge clk_sys);
    tsr_load <= 1'b0;
    #1 bchk(thr_irq_q, 1'b1);
    rchk(3'h5, 8'h20);
    @(posedge clk_sys);
    tsr_empty <= 1'b1;
    rchk(3'h5, 8'h60);
    tdone(2);
    // receive without fifos: framing error then overrun
    rx_char(1'b0, 1'b1);
    bchk(pushed, 1'b1);
    rx_char(1'b0, 1'b0);
    bchk(pushed, 1'b0);
    rchk(3'h5, 8'h6B);
    rchk(3'h5, 8'h61);
    @(posedge clk_sys);
    rx_pop <= 1'b1;
    @(posedge clk_sys);
    rx_pop <= 1'b0;
    #1 bchk(data_ready_q, 1'b0);
    rchk(3'h5, 8'h60);
    tdone(3);
    // fifo mode: transmit empty, parity error, fill to overrun
    u_ulst_host_model.bus_write(3'h1, 8'h03);
    @(posedge clk_sys);
    thr_write <= 1'b1;
    tx_fifo_empty <= 1'b0;
    @(posedge clk_sys);
    thr_write <= 1'b0;
    tx_fifo_empty <= 1'b1;
    #1 bchk(thr_irq_q, 1'b0);
    @(posedge clk_sys);
    #1 bchk(thr_irq_q, 1'b1);
    rx_char(1'b1, 1'b0);
    rchk(3'h5, 8'hE5);
    rchk(3'h5, 8'h61);
    for (i = 0; i < 31; i = i + 1) rx_char(1'b0, 1'b0);
    rchk(3'h6, 8'h20);
    rx_char(1'b0, 1'b0);
    bchk(pushed, 1'b0);
    rchk(3'h5, 8'h63);
    tdone(4);
    // long break gives one break character
    u_ulst_host_model.bus_write(3'h1, 8'h01);
    u_ulst_host_model.bus_write(3'h1, 8'h03);
    rchk(3'h5, 8'h60);
    brk_cnt = 0;
    @(posedge clk_sys);
    rx_pin <= 1'b0;
    repeat (400) @(posedge clk_sys);
    rx_pin <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk(brk_cnt[7:0], 8'h01);
    rchk(3'h5, 8'hF9);
    tdone(5);
    complete_run;
  end
endmodule // ulst_top_tb_top

bind ulst_top ulst_top_props u_ulst_top_props (
  .clk_sys, .resetn, .ce, .addr, .wdata, .wr, .rd, .rd_data_q, .thr_write, .tsr_load,
  .tx_fifo_empty, .tsr_empty, .rx_char_valid, .rx_pop, .rx_push_q, .rx_push_brk_q,
  .thr_irq_q, .data_ready_q
);
